// >>> logic/prot_gate_cfg.svh
`ifndef PROT_GATE_CFG_SVH
`define PROT_GATE_CFG_SVH

// register byte offsets
`define OFS_CTRL      8'h00
`define OFS_MOD_EN    8'h04
`define OFS_BLK_PERM  8'h08
`define OFS_TRIP_INH  8'h0c
`define OFS_TRIP_PERM 8'h10
`define OFS_SRC_SEL   8'h14
`define OFS_GND_CFG   8'h18
`define OFS_NV_DELAY  8'h1c
`define OFS_STATUS    8'h20
`define OFS_IRQ_STAT  8'h24
`define OFS_IRQ_MASK  8'h28
`define OFS_GND_STATE 8'h2c

// control register fields
`define CTRL_PROT_EN  0
`define CTRL_PERM_BIT 1

// ground stage configuration fields
`define GND_DIR_LO    0
`define GND_SUPV_BIT  2
`define GND_SRC_BIT   3

// source selector fields: bit 5 picks a digital input indexed by bits 2:0, else bits 4:0 index an internal signal
`define SRC_IS_PIN    5

// reset values
`define RST_NV_DELAY  16'h0000
`define RST_OP_DELAY  16'h0000

// number of internal signals and digital inputs offered as block sources, and number of modules
`define N_INT_SIG     32
`define N_DIG_IN      8
`define N_MOD         8

`endif

// >>> logic/prot_gate_pkg.sv
`default_nettype none
package prot_gate_pkg;

    // ground stage direction mode
    typedef enum logic [1:0] {
        dir_none_type_val = 2'h0,
        dir_fwd_type_val = 2'h1,
        dir_rev_type_val = 2'h2
    } dir_mode_type;

    // ground stage timing state, one-hot
    typedef enum logic [3:0] {
        st_idle = 4'h1,
        st_nv_wait = 4'h2,
        st_op_wait = 4'h4,
        st_trip = 4'h8
    } gnd_state_type;

endpackage
`default_nettype wire

// >>> logic/protection_blocking_gate.sv
// How it works
// - global enable off suppresses every pickup, alarm and trip
// - each module enable off stops evaluation and all outputs of that module
// - permanent trip inhibit per stage holds its breaker trip low
// - global unit blocked while its assigned source is active and permitted
// - module blocked when permitted and either general block source active
// - stage trip suppressed when trip-block permitted and its source active
// - each block source selects a digital input or an internal signal
// - current modules also blocked by reverse interlocking
// - supervision-only ground stage gives no alarm or trip, still evaluates
// - ground stage operates only for forward, only for reverse, or for either direction per setting
// - ground stage takes measured or sensitive ground current per setting
// - ground operate delay starts only after direction release
// - neutral voltage above threshold starts release timer before direction
`timescale 1ns/1ps
`default_nettype none
`include "prot_gate_cfg.svh"

module protection_blocking_gate
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    input wire logic [`N_INT_SIG-1:0] int_signals,
    input wire logic [`N_DIG_IN-1:0] dig_inputs,
    input wire logic [`N_MOD-1:0] mod_pickup,
    input wire logic [`N_MOD-1:0] mod_trip_cond,
    input wire logic [`N_MOD-1:0] mod_is_current,
    input wire logic reverse_interlock,
    input wire logic measured_ground_over,
    input wire logic sensitive_ground_over,
    input wire logic neutral_voltage_over,
    input wire logic dir_forward,
    input wire logic dir_reverse,
    output logic [`N_MOD-1:0] mod_active,
    output logic [`N_MOD-1:0] mod_alarm,
    output logic [`N_MOD-1:0] mod_trip_cmd,
    output logic gnd_alarm,
    output logic gnd_trip_cmd,
    output logic gnd_supv_flag,
    output logic irq
);

    logic [31:0] ctrl_reg;
    logic [`N_MOD-1:0] mod_en_reg;
    logic [`N_MOD-1:0] blk_perm_reg;
    logic [`N_MOD:0] trip_inh_reg;
    logic [`N_MOD:0] trip_perm_reg;
    logic [5:0] src_prot_reg;
    logic [5:0] src_a_reg;
    logic [5:0] src_b_reg;
    logic [5:0] src_trip_reg;
    logic [3:0] gnd_cfg_reg;
    logic [15:0] nv_delay_reg;
    logic [15:0] op_delay_reg;
    logic [3:0] irq_stat_reg;
    logic [3:0] irq_mask_reg;
    logic [15:0] cnt_reg;
    logic [31:0] rdata_reg;
    prot_gate_pkg::gnd_state_type state_reg;
    prot_gate_pkg::gnd_state_type state_next;

    // a selector code picks one digital input or one internal signal
    function automatic logic pick_src(input logic [5:0] sel,
                                      input logic [`N_INT_SIG-1:0] ints,
                                      input logic [`N_DIG_IN-1:0] pins);
        logic v;
        v = 1'b0;
        if (sel[`SRC_IS_PIN])
        begin
            v = pins[sel[2:0]];
        end
        else
        begin
            v = ints[sel[4:0]];
        end
        return v;
    endfunction

    logic blk_prot_src;
    logic blk_a_src;
    logic blk_b_src;
    logic trip_blk_src;
    logic prot_on;
    logic prot_blocked;
    logic gnd_dir_ok;
    logic gnd_over;
    logic gnd_run;
    logic gnd_trip_int;
    logic [`N_MOD-1:0] mod_ok;
    logic [`N_MOD-1:0] trip_next;
    logic [3:0] events;

    assign blk_prot_src = pick_src(src_prot_reg, int_signals, dig_inputs);
    assign blk_a_src = pick_src(src_a_reg, int_signals, dig_inputs);
    assign blk_b_src = pick_src(src_b_reg, int_signals, dig_inputs);
    assign trip_blk_src = pick_src(src_trip_reg, int_signals, dig_inputs);

    assign prot_blocked = ctrl_reg[`CTRL_PERM_BIT] & blk_prot_src;
    assign prot_on = ctrl_reg[`CTRL_PROT_EN] & ~prot_blocked;

    genvar gi;
    generate
        for (gi = 0; gi < `N_MOD; gi = gi + 1)
        begin : g_mod
            assign mod_ok[gi] = prot_on & mod_en_reg[gi]
                & ~(blk_perm_reg[gi] & (blk_a_src | blk_b_src))
                & ~(mod_is_current[gi] & reverse_interlock);
            assign trip_next[gi] = mod_ok[gi] & mod_trip_cond[gi]
                & ~trip_inh_reg[gi]
                & ~(trip_perm_reg[gi] & trip_blk_src);
        end
    endgenerate

    // ground stage occupies slot N_MOD of the trip inhibit and trip permit fields, but shares slot 0 of the enable and block permit fields
    assign gnd_run = prot_on & mod_en_reg[0] & ~reverse_interlock
        & ~(blk_perm_reg[0] & (blk_a_src | blk_b_src));
    assign gnd_over = gnd_cfg_reg[`GND_SRC_BIT] ? sensitive_ground_over
        : measured_ground_over;
    always_comb
    begin
        case (gnd_cfg_reg[1:0])
            prot_gate_pkg::dir_fwd_type_val: gnd_dir_ok = dir_forward;
            prot_gate_pkg::dir_rev_type_val: gnd_dir_ok = dir_reverse;
            default: gnd_dir_ok = 1'b1;
        endcase
    end

    // release delay runs first, the operate delay only after it: they add
    always_comb
    begin
        state_next = state_reg;
        if (!(gnd_run && gnd_over && neutral_voltage_over))
        begin
            state_next = prot_gate_pkg::st_idle;
        end
        else
        begin
            case (state_reg)
                prot_gate_pkg::st_idle: state_next = prot_gate_pkg::st_nv_wait;
                prot_gate_pkg::st_nv_wait:
                    if (cnt_reg >= nv_delay_reg && gnd_dir_ok)
                    begin
                        state_next = prot_gate_pkg::st_op_wait;
                    end
                prot_gate_pkg::st_op_wait:
                    if (!gnd_dir_ok)
                    begin
                        state_next = prot_gate_pkg::st_nv_wait;
                    end
                    else if (cnt_reg >= op_delay_reg)
                    begin
                        state_next = prot_gate_pkg::st_trip;
                    end
                prot_gate_pkg::st_trip:
                    if (!gnd_dir_ok)
                    begin
                        state_next = prot_gate_pkg::st_nv_wait;
                    end
                default: state_next = prot_gate_pkg::st_idle;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= prot_gate_pkg::st_idle;
            cnt_reg <= 16'h0000;
        end
        else
        begin
            state_reg <= state_next;
            if (state_next != state_reg)
            begin
                cnt_reg <= 16'h0000;
            end
            else if (cnt_reg != 16'hffff)
            begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
        end
    end

    // gnd_run gates here too: the state register lags a block by one cycle
    assign gnd_trip_int = (state_reg == prot_gate_pkg::st_trip) & gnd_run
        & ~trip_inh_reg[`N_MOD]
        & ~(trip_perm_reg[`N_MOD] & trip_blk_src);

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            mod_active <= 8'h00;
            mod_alarm <= 8'h00;
            mod_trip_cmd <= 8'h00;
            gnd_alarm <= 1'b0;
            gnd_trip_cmd <= 1'b0;
            gnd_supv_flag <= 1'b0;
        end
        else
        begin
            mod_active <= mod_ok;
            mod_alarm <= mod_ok & mod_pickup;
            mod_trip_cmd <= trip_next;
            gnd_supv_flag <= gnd_trip_int;
            // alarm only once the chosen direction has been released
            gnd_alarm <= ((state_reg == prot_gate_pkg::st_op_wait)
                | (state_reg == prot_gate_pkg::st_trip)) & gnd_run
                & ~gnd_cfg_reg[`GND_SUPV_BIT];
            gnd_trip_cmd <= gnd_trip_int & ~gnd_cfg_reg[`GND_SUPV_BIT];
        end
    end

    // events: trip, ground trip, protection blocked, general block
    assign events = {blk_a_src | blk_b_src, prot_blocked, gnd_trip_int, |trip_next};

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_stat_reg <= 4'h0;
        end
        else
        begin
            // set wins over a simultaneous write-one clear
            irq_stat_reg <= (irq_stat_reg
                & ~((wr_stb && addr == `OFS_IRQ_STAT) ? wdata[3:0] : 4'h0)) | events;
        end
    end
    assign irq = |(irq_stat_reg & irq_mask_reg);

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_reg <= 32'h00000000;
            mod_en_reg <= 8'h00;
            blk_perm_reg <= 8'h00;
            trip_inh_reg <= 9'h000;
            trip_perm_reg <= 9'h000;
            src_prot_reg <= 6'h00;
            src_a_reg <= 6'h00;
            src_b_reg <= 6'h00;
            src_trip_reg <= 6'h00;
            gnd_cfg_reg <= 4'h0;
            nv_delay_reg <= `RST_NV_DELAY;
            op_delay_reg <= `RST_OP_DELAY;
            irq_mask_reg <= 4'h0;
        end
        else if (wr_stb)
        begin
            case (addr)
                `OFS_CTRL: ctrl_reg <= {30'h0, wdata[1:0]};
                `OFS_MOD_EN: mod_en_reg <= wdata[7:0];
                `OFS_BLK_PERM: blk_perm_reg <= wdata[7:0];
                `OFS_TRIP_INH: trip_inh_reg <= wdata[8:0];
                `OFS_TRIP_PERM: trip_perm_reg <= wdata[8:0];
                `OFS_SRC_SEL:
                begin
                    src_prot_reg <= wdata[5:0];
                    src_a_reg <= wdata[13:8];
                    src_b_reg <= wdata[21:16];
                    src_trip_reg <= wdata[29:24];
                end
                `OFS_GND_CFG: gnd_cfg_reg <= wdata[3:0];
                `OFS_NV_DELAY:
                begin
                    nv_delay_reg <= wdata[15:0];
                    op_delay_reg <= wdata[31:16];
                end
                `OFS_IRQ_MASK: irq_mask_reg <= wdata[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata_reg <= 32'h00000000;
        end
        else if (rd_stb)
        begin
            case (addr)
                `OFS_CTRL: rdata_reg <= ctrl_reg;
                `OFS_MOD_EN: rdata_reg <= {24'h0, mod_en_reg};
                `OFS_BLK_PERM: rdata_reg <= {24'h0, blk_perm_reg};
                `OFS_TRIP_INH: rdata_reg <= {23'h0, trip_inh_reg};
                `OFS_TRIP_PERM: rdata_reg <= {23'h0, trip_perm_reg};
                `OFS_SRC_SEL: rdata_reg <= {2'h0, src_trip_reg, 2'h0, src_b_reg,
                    2'h0, src_a_reg, 2'h0, src_prot_reg};
                `OFS_GND_CFG: rdata_reg <= {28'h0, gnd_cfg_reg};
                `OFS_NV_DELAY: rdata_reg <= {op_delay_reg, nv_delay_reg};
                `OFS_STATUS: rdata_reg <= {14'h0, prot_blocked, prot_on, mod_trip_cmd,
                    mod_alarm};
                `OFS_IRQ_STAT: rdata_reg <= {28'h0, irq_stat_reg};
                `OFS_IRQ_MASK: rdata_reg <= {28'h0, irq_mask_reg};
                `OFS_GND_STATE: rdata_reg <= {28'h0, state_reg};
                default: rdata_reg <= 32'h00000000;
            endcase
        end
        else
        begin
            rdata_reg <= 32'h00000000;
        end
    end
    assign rdata = rdata_reg;

    global_off_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !ctrl_reg[`CTRL_PROT_EN] |=> (mod_trip_cmd == 8'h00) && !gnd_trip_cmd)
        else $error("trip while protection disabled");
    mod_off_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !mod_en_reg[1] |=> !mod_active[1] && !mod_alarm[1])
        else $error("disabled module active");
    trip_inhibit_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        trip_inh_reg[2] |=> !mod_trip_cmd[2])
        else $error("inhibited stage tripped");
    global_block_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        prot_blocked |=> mod_active == 8'h00)
        else $error("module active while globally blocked");
    gen_block_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        blk_perm_reg[3] && (blk_a_src || blk_b_src) |=> !mod_active[3])
        else $error("module active while blocked");
    trip_block_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        trip_perm_reg[4] && trip_blk_src |=> !mod_trip_cmd[4])
        else $error("trip passed external trip block");
    rev_lock_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        mod_is_current[5] && reverse_interlock |=> !mod_active[5])
        else $error("current module active under interlock");
    supv_only_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        gnd_cfg_reg[`GND_SUPV_BIT] |=> !gnd_trip_cmd && !gnd_alarm)
        else $error("supervision stage tripped");
    delay_order_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        state_reg == prot_gate_pkg::st_nv_wait && state_next == prot_gate_pkg::st_op_wait
        |-> cnt_reg >= nv_delay_reg && gnd_dir_ok)
        else $error("operate delay began before release");
    trip_eq_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        mod_trip_cmd[0] |-> $past(mod_trip_cond[0]) && $past(mod_ok[0]))
        else $error("trip without internal condition");

    trip_seen_c: cover property (@(posedge clk_sys) disable iff (!nrst) |mod_trip_cmd);
    gnd_trip_c: cover property (@(posedge clk_sys) disable iff (!nrst) gnd_trip_cmd);
    supv_c: cover property (@(posedge clk_sys) disable iff (!nrst) gnd_supv_flag
        && gnd_cfg_reg[`GND_SUPV_BIT]);
    irq_c: cover property (@(posedge clk_sys) disable iff (!nrst) irq);

endmodule
`default_nettype wire

// >>> dv/block_source_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "prot_gate_cfg.svh"

module block_source_model
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [`N_INT_SIG-1:0] int_req,
    input wire logic [`N_DIG_IN-1:0] dig_req,
    output logic [`N_INT_SIG-1:0] int_signals,
    output logic [`N_DIG_IN-1:0] dig_inputs
);
    // sources settle one cycle late, as the relay's signal list does
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            int_signals <= '0;
            dig_inputs <= '0;
        end
        else
        begin
            int_signals <= int_req;
            dig_inputs <= dig_req;
        end
    end
endmodule
`default_nettype wire

// >>> dv/test_protection_blocking_gate.sv
`timescale 1ns/1ps
`default_nettype none
`include "prot_gate_cfg.svh"

module test_protection_blocking_gate;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [31:0] rdata, int_signals, v;
    logic [31:0] int_req = 32'h0;
    logic [7:0] dig_req = 8'h0;
    logic [7:0] dig_inputs, mod_active, mod_alarm, mod_trip_cmd;
    logic [7:0] mod_pickup = 8'h0;
    logic [7:0] mod_trip_cond = 8'h0;
    logic [7:0] mod_is_current = 8'h0;
    logic reverse_interlock = 1'b0;
    logic measured_ground_over = 1'b0;
    logic sensitive_ground_over = 1'b0;
    logic neutral_voltage_over = 1'b0;
    logic dir_forward = 1'b0;
    logic dir_reverse = 1'b0;
    logic gnd_alarm, gnd_trip_cmd, gnd_supv_flag, irq;
    logic look = 1'b0;
    logic rd_seen = 1'b0;
    logic [33:0] note;
    logic [33:0] exp_q[$];
    int failures = 0;
    int check_count = 0;
    int cyc = 0;

    protection_blocking_gate protection_blocking_gate_i (.clk_sys, .nrst, .addr, .wdata,
        .wr_stb, .rd_stb, .rdata, .int_signals, .dig_inputs, .mod_pickup, .mod_trip_cond,
        .mod_is_current, .reverse_interlock, .measured_ground_over, .sensitive_ground_over,
        .neutral_voltage_over, .dir_forward, .dir_reverse, .mod_active, .mod_alarm,
        .mod_trip_cmd, .gnd_alarm, .gnd_trip_cmd, .gnd_supv_flag, .irq);

    block_source_model block_source_model_i (.clk_sys, .nrst, .int_req, .dig_req,
        .int_signals, .dig_inputs);

    always #2.5 clk_sys = ~clk_sys;

    function automatic logic [31:0] seen_of(input logic [1:0] s);
        case (s)
            2'h0: seen_of = rdata;
            2'h1: seen_of = {16'h0, mod_alarm, mod_trip_cmd};
            2'h2: seen_of = {24'h0, mod_active};
            default: seen_of = {28'h0, gnd_alarm, irq, gnd_supv_flag, gnd_trip_cmd};
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        check_count++;
        if (seen !== expv)
        begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // monitor: rdata only stands in the cycle after the read strobe
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if ((rd_seen || look) && exp_q.size() > 0)
        begin
            note = exp_q.pop_front();
            check(seen_of(note[33:32]), note[31:0]);
        end
        rd_seen <= rd_stb;
        if (cyc == 5000)
        begin
            failures++;
            complete_run();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // strobes drop with a gap cycle so no signal is assigned twice in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back({2'h0, e});
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic chk(input logic [1:0] s, input logic [31:0] e);
        exp_q.push_back({s, e});
        look <= 1'b1;
        @(posedge clk_sys);
        look <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic blk(input logic [31:0] i, input logic [7:0] d, input logic [7:0] e);
        int_req <= i;
        dig_req <= d;
        tick(4);
        chk(2'h1, {24'h0, e});
    endtask

    // drv is {sensitive over, measured over, reverse, forward}
    task automatic gnd(input logic [3:0] cfg, input logic [3:0] drv, input logic [3:0] e);
        wr(`OFS_GND_CFG, {28'h0, cfg});
        dir_forward <= drv[0];
        dir_reverse <= drv[1];
        measured_ground_over <= drv[2];
        sensitive_ground_over <= drv[3];
        neutral_voltage_over <= 1'b1;
        tick(5);
        chk(2'h3, 32'h0);
        tick(30);
        chk(2'h3, {28'h0, e});
        measured_ground_over <= 1'b0;
        sensitive_ground_over <= 1'b0;
        neutral_voltage_over <= 1'b0;
        tick(4);
    endtask

    initial
    begin
        void'($urandom(32'h06b8));
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rd(`OFS_CTRL, 32'h0);
        rd(`OFS_STATUS, 32'h0);
        rd(8'h80, 32'h0);
        mod_trip_cond <= 8'hff;
        mod_pickup <= 8'hff;
        wr(`OFS_MOD_EN, 32'hff);
        tick(2);
        chk(2'h1, 32'h0);
        $display("test global off done");
        wr(`OFS_CTRL, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            v = $urandom();
            mod_trip_cond <= v[7:0];
            mod_pickup <= v[15:8];
            wr(`OFS_MOD_EN, {24'h0, v[23:16]});
            wr(`OFS_TRIP_INH, {24'h0, v[31:24]});
            tick(2);
            chk(2'h2, {24'h0, v[23:16]});
            chk(2'h1, {16'h0, v[15:8] & v[23:16], v[7:0] & v[23:16] & ~v[31:24]});
        end
        rd(`OFS_MOD_EN, {24'h0, v[23:16]});
        $display("test enable and inhibit done");
        mod_pickup <= 8'h0;
        mod_trip_cond <= 8'hff;
        wr(`OFS_MOD_EN, 32'hff);
        wr(`OFS_TRIP_INH, 32'h0);
        wr(`OFS_BLK_PERM, 32'h0f);
        wr(`OFS_TRIP_PERM, 32'h30);
        wr(`OFS_SRC_SEL, 32'h05220307);
        blk(32'h8, 8'h0, 8'hf0);
        blk(32'h0, 8'h4, 8'hf0);
        blk(32'h20, 8'h0, 8'hcf);
        blk(32'h80, 8'h0, 8'hff);
        wr(`OFS_CTRL, 32'h3);
        blk(32'h80, 8'h0, 8'h00);
        blk(32'h0, 8'h0, 8'hff);
        mod_is_current <= 8'h3c;
        reverse_interlock <= 1'b1;
        tick(3);
        chk(2'h1, 32'hc3);
        rd(`OFS_STATUS, 32'h0001c300);
        $display("test blocking done");
        wr(`OFS_IRQ_MASK, 32'h1);
        chk(2'h3, 32'h4);
        wr(`OFS_IRQ_STAT, 32'h1);
        chk(2'h3, 32'h4);
        wr(`OFS_IRQ_MASK, 32'h0);
        chk(2'h3, 32'h0);
        mod_trip_cond <= 8'h0;
        reverse_interlock <= 1'b0;
        tick(3);
        wr(`OFS_IRQ_STAT, 32'hf);
        rd(`OFS_IRQ_STAT, 32'h0);
        $display("test interrupt done");
        wr(`OFS_NV_DELAY, 32'h00040003);
        gnd(4'h1, 4'b0101, 4'b1011);
        gnd(4'h2, 4'b0101, 4'b0000);
        gnd(4'h2, 4'b0110, 4'b1011);
        gnd(4'h9, 4'b0101, 4'b0000);
        gnd(4'h9, 4'b1001, 4'b1011);
        gnd(4'h5, 4'b0101, 4'b0010);
        wr(`OFS_GND_CFG, 32'h1);
        dir_forward <= 1'b1;
        measured_ground_over <= 1'b1;
        neutral_voltage_over <= 1'b1;
        tick(20);
        chk(2'h3, 32'hb);
        wr(`OFS_CTRL, 32'h0);
        chk(2'h3, 32'h0);
        $display("test ground stage done");
        complete_run();
    end
endmodule
`default_nettype wire
